//--- src/mcp_consts.vh
/*
 Constants for the memory configuration and PROM programming control block:
 register indices and bus addresses, field positions, reset values, memory
 map boundaries and answer codes. Assumes inclusion by bare name.
*/
`ifndef MCP_CONSTS_VH
`define MCP_CONSTS_VH

// Register indices as printed; byte address is four times the index
`define MCP_IDX_PROM_PROGRAM_CONTROL 16'h001C
`define MCP_IDX_OPTION 16'h1FDF
`define MCP_BUS_AW 15
`define MCP_ADDR_PROM_PROGRAM_CONTROL 15'h0070
`define MCP_ADDR_OPTION 15'h7F7C

// Option register fields
`define MCP_OPT_PAGE_ZERO_RAM_SELECT 7
`define MCP_OPT_PAGE_ONE_RAM_SELECT 6
`define MCP_OPT_SEC 3
`define MCP_OPT_SPARE 2
`define MCP_OPT_IRQ 1

// Programming register fields and reset value
`define MCP_PRG_LAT 2
`define MCP_PRG_PGM 0
`define MCP_PRG_RESET 8'h00

// Memory map, 13-bit CPU address
`define MCP_CPU_AW 13
`define MCP_REG_TOP 13'h001F
`define MCP_PZ_RSVD_TOP 13'h002F
`define MCP_PZ_TOP 13'h004F
`define MCP_RAM_TOP 13'h00FF
`define MCP_P1_TOP 13'h015F
`define MCP_PROM_TOP 13'h1EFF
`define MCP_OPT_ADDR 13'h1FDF
`define MCP_VEC_LO 13'h1FF4

// Decode region codes
`define MCP_RG_REGS 3'h0
`define MCP_RG_RAM 3'h1
`define MCP_RG_PROM 3'h2
`define MCP_RG_BOOT 3'h3
`define MCP_RG_OPTION 3'h4
`define MCP_RG_VECTOR 3'h5
`define MCP_RG_RSVD 3'h6

// Misc
`define MCP_SP_RESET 8'hFF
`define MCP_PROM_ERASED 8'h00
`define MCP_RESP_OKAY 2'h0
`define MCP_RESP_SLVERR 2'h2
`define MCP_STRAP_WAIT 2'h3

`endif

//--- src/mcp_memory_ctrl.v
/*
 Memory configuration and PROM programming control: option and programming
 registers behind an AXI4-Lite slave, CPU address decode, stack pointer and
 PROM address/data latches.
 Assumes one clock aclk with synchronous active-low reset; the CPU port is on
 aclk; the lockout strap comes from a pin and is synchronised here.
*/
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "mcp_consts.vh"

module mcp_memory_ctrl (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address and data
    input wire awvalid,
    output reg awready,
    input wire [`MCP_BUS_AW-1:0] awaddr,
    input wire [2:0] awprot,
    input wire wvalid,
    output reg wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    // AXI4-Lite write response
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    // AXI4-Lite read
    input wire arvalid,
    output reg arready,
    input wire [`MCP_BUS_AW-1:0] araddr,
    input wire [2:0] arprot,
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    // CPU side
    input wire [`MCP_CPU_AW-1:0] cpu_addr,
    input wire [7:0] cpu_wdata,
    input wire cpu_wr,
    input wire stack_push,
    input wire stack_pull,
    output reg [2:0] cpu_region,
    output reg [7:0] stack_ptr,
    // Nonvolatile lockout cell and mode outputs
    input wire lockout_cell_in,
    output reg bootloader_enable,
    output reg irq_level_sense,
    output reg page_zero_ram_select,
    output reg page_one_ram_select,
    // PROM programming
    output reg [`MCP_CPU_AW-1:0] prom_latch_addr,
    output reg [7:0] prom_latch_data,
    output reg prom_latched,
    output reg prom_high_voltage_enable
);

    reg aw_held;
    reg w_held;
    reg [`MCP_BUS_AW-1:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg prom_latch_enable;
    reg irq_written;
    reg opt_spare;
    reg bootloader_lockout;
    reg lk_s1;
    reg lk_s2;
    reg lk_s3;
    reg [1:0] strap_cnt;
    reg strap_loaded;
    reg [7:0] opt_read;
    reg [7:0] prom_program_control_read;
    reg [2:0] next_region;
    wire wr_go;
    wire wr_opt;
    wire wr_prom_program_control;
    wire [7:0] wbyte;

    assign wr_go = aw_held && w_held && !bvalid;
    assign wr_opt = wr_go && w_strb_q[0] && (aw_addr_q == `MCP_ADDR_OPTION);
    assign wr_prom_program_control = wr_go && w_strb_q[0] && (aw_addr_q == `MCP_ADDR_PROM_PROGRAM_CONTROL);
    assign wbyte = w_data_q[7:0];

    // Read views; unused bits forced to zero
    always @* begin
        opt_read = 8'h00;
        opt_read[`MCP_OPT_PAGE_ZERO_RAM_SELECT] = page_zero_ram_select;
        opt_read[`MCP_OPT_PAGE_ONE_RAM_SELECT] = page_one_ram_select;
        opt_read[`MCP_OPT_SEC] = bootloader_lockout;
        opt_read[`MCP_OPT_SPARE] = opt_spare;
        opt_read[`MCP_OPT_IRQ] = irq_level_sense;
        prom_program_control_read = 8'h00;
        prom_program_control_read[`MCP_PRG_LAT] = prom_latch_enable;
        prom_program_control_read[`MCP_PRG_PGM] = prom_high_voltage_enable;
    end

    // Address decode; region tracks RAM-select bits on the next edge
    always @* begin
        if (cpu_addr <= `MCP_REG_TOP) begin
            next_region = `MCP_RG_REGS;
        end else if (cpu_addr <= `MCP_PZ_RSVD_TOP) begin
            next_region = page_zero_ram_select ? `MCP_RG_RSVD : `MCP_RG_PROM;
        end else if (cpu_addr <= `MCP_PZ_TOP) begin
            next_region = page_zero_ram_select ? `MCP_RG_RAM : `MCP_RG_PROM;
        end else if (cpu_addr <= `MCP_RAM_TOP) begin
            next_region = `MCP_RG_RAM;
        end else if (cpu_addr <= `MCP_P1_TOP) begin
            next_region = page_one_ram_select ? `MCP_RG_RAM : `MCP_RG_PROM;
        end else if (cpu_addr <= `MCP_PROM_TOP) begin
            next_region = `MCP_RG_PROM;
        end else if (cpu_addr == `MCP_OPT_ADDR) begin
            next_region = `MCP_RG_OPTION;
        end else if (cpu_addr >= `MCP_VEC_LO) begin
            next_region = `MCP_RG_VECTOR;
        end else begin
            next_region = `MCP_RG_BOOT;
        end
    end

    // Lockout strap synchroniser; first stage feeds only the second
    always @(posedge aclk) begin
        lk_s1 <= lockout_cell_in;
        lk_s2 <= lk_s1;
        lk_s3 <= lk_s2;
    end

    // Lockout cell: no reset term, it models a nonvolatile bit
    always @(posedge aclk) begin
        if (!strap_loaded && strap_cnt == `MCP_STRAP_WAIT && lk_s2 == lk_s3) begin
            bootloader_lockout <= lk_s3;
        end else if (wr_opt && wbyte[`MCP_OPT_SEC] && prom_high_voltage_enable) begin
            bootloader_lockout <= 1'b1;
        end
        if (wr_opt) begin
            opt_spare <= wbyte[`MCP_OPT_SPARE];
        end
    end

    // Reset-aware control state
    always @(posedge aclk) begin
        if (!aresetn) begin
            strap_cnt <= 2'h0;
            strap_loaded <= 1'b0;
            bootloader_enable <= 1'b0;
            page_zero_ram_select <= 1'b0;
            page_one_ram_select <= 1'b0;
            irq_level_sense <= 1'b1;
            irq_written <= 1'b0;
            cpu_region <= `MCP_RG_REGS;
            stack_ptr <= `MCP_SP_RESET;
        end else begin
            if (strap_cnt != `MCP_STRAP_WAIT) begin
                strap_cnt <= strap_cnt + 2'h1;
            end else if (!strap_loaded && lk_s2 == lk_s3) begin
                strap_loaded <= 1'b1;
            end
            // Held disabled until the cell is known; safe default
            if (strap_loaded) begin
                bootloader_enable <= !bootloader_lockout;
            end
            if (wr_opt) begin
                page_zero_ram_select <= wbyte[`MCP_OPT_PAGE_ZERO_RAM_SELECT];
                page_one_ram_select <= wbyte[`MCP_OPT_PAGE_ONE_RAM_SELECT];
                irq_written <= 1'b1;
                if (!irq_written && !wbyte[`MCP_OPT_IRQ]) begin
                    irq_level_sense <= 1'b0;
                end
            end
            cpu_region <= next_region;
            if (stack_push && !stack_pull) begin
                stack_ptr <= stack_ptr - 8'h01;
            end else if (stack_pull && !stack_push) begin
                stack_ptr <= stack_ptr + 8'h01;
            end
        end
    end

    // Programming register and PROM latches
    always @(posedge aclk) begin
        if (!aresetn) begin
            prom_latch_enable <= 1'b0;
            prom_high_voltage_enable <= 1'b0;
            prom_latched <= 1'b0;
            prom_latch_addr <= {`MCP_CPU_AW{1'b0}};
            prom_latch_data <= `MCP_PROM_ERASED;
        end else begin
            if (wr_prom_program_control) begin
                prom_latch_enable <= wbyte[`MCP_PRG_LAT];
                // Voltage needs latch enable already on; clearing latch drops it
                prom_high_voltage_enable <= wbyte[`MCP_PRG_PGM] && prom_latch_enable
                    && wbyte[`MCP_PRG_LAT];
                if (!wbyte[`MCP_PRG_LAT]) begin
                    prom_latched <= 1'b0;
                end
            end
            // Only the first write after enabling is captured; later ones leave the
            // latches alone so a running program pulse sees stable values
            if (cpu_wr && prom_latch_enable && !prom_latched) begin
                prom_latched <= 1'b1;
                prom_latch_addr <= cpu_addr;
                prom_latch_data <= cpu_wdata;
            end
        end
    end

    // AXI4-Lite write channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= {`MCP_BUS_AW{1'b0}};
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `MCP_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wready <= 1'b0;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                if (aw_addr_q == `MCP_ADDR_OPTION || aw_addr_q == `MCP_ADDR_PROM_PROGRAM_CONTROL) begin
                    bresp <= `MCP_RESP_OKAY;
                end else begin
                    bresp <= `MCP_RESP_SLVERR;
                end
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `MCP_RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                case (araddr)
                    `MCP_ADDR_OPTION: begin
                        rdata <= {24'h000000, opt_read};
                        rresp <= `MCP_RESP_OKAY;
                    end
                    `MCP_ADDR_PROM_PROGRAM_CONTROL: begin
                        rdata <= {24'h000000, prom_program_control_read};
                        rresp <= `MCP_RESP_OKAY;
                    end
                    default: begin
                        rdata <= 32'h00000000;
                        rresp <= `MCP_RESP_SLVERR;
                    end
                endcase
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

endmodule

//--- dv/mcp_memory_ctrl_sva.sv
/*
 Port checker for the memory control block: decode, stack and latches.
 Assumes it is bound to mcp_memory_ctrl, one clock, synchronous reset.
*/
`timescale 1ns/10ps
`include "mcp_consts.vh"
module mcp_memory_ctrl_sva (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // CPU side
    input wire [12:0] cpu_addr,
    input wire stack_push,
    input wire stack_pull,
    input wire [2:0] cpu_region,
    input wire [7:0] stack_ptr,
    // Modes and latches
    input wire irq_level_sense,
    input wire page_zero_ram_select,
    input wire page_one_ram_select,
    input wire [12:0] prom_latch_addr,
    input wire prom_latched,
    input wire prom_high_voltage_enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_push;
        stack_push && !stack_pull |=> stack_ptr == $past(stack_ptr) - 8'h01;
    endproperty
    a_push: assert property (p_push) else $error("push step wrong");
    property p_pull;
        stack_pull && !stack_push |=> stack_ptr == $past(stack_ptr) + 8'h01;
    endproperty
    a_pull: assert property (p_pull) else $error("pull step wrong");
    property p_vec;
        cpu_addr >= `MCP_VEC_LO |=> cpu_region == `MCP_RG_VECTOR;
    endproperty
    a_vec: assert property (p_vec) else $error("vector decode wrong");
    property p_rsvd;
        page_zero_ram_select && cpu_addr[12:4] == 9'h002 |=> cpu_region == `MCP_RG_RSVD;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved decode wrong");
    property p_pz0;
        !page_zero_ram_select && cpu_addr >= 13'h0020 && cpu_addr <= `MCP_PZ_TOP
            |=> cpu_region == `MCP_RG_PROM;
    endproperty
    a_pz0: assert property (p_pz0) else $error("page zero PROM wrong");
    // Decode uses the select as it stood before the edge
    property p_p1;
        cpu_addr >= 13'h0100 && cpu_addr <= `MCP_P1_TOP
            |=> cpu_region == ($past(page_one_ram_select) ? `MCP_RG_RAM : `MCP_RG_PROM);
    endproperty
    a_p1: assert property (p_p1) else $error("page one decode wrong");
    property p_rst;
        disable iff (1'b0) !aresetn |=> !page_zero_ram_select && !page_one_ram_select
            && irq_level_sense;
    endproperty
    a_rst: assert property (p_rst) else $error("option reset wrong");
    property p_prst;
        disable iff (1'b0) !aresetn |=> !prom_high_voltage_enable && !prom_latched
            && stack_ptr == `MCP_SP_RESET;
    endproperty
    a_prst: assert property (p_prst) else $error("program reset wrong");
    property p_hold;
        prom_latched && $past(prom_latched) |-> $stable(prom_latch_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("latch not held");
endmodule

//--- dv/mcp_prom_model.sv
/*
 PROM array model fed by the block's latches.
 Assumes latch and voltage outputs of mcp_memory_ctrl on aclk.
*/
`timescale 1ns/10ps
`include "mcp_consts.vh"
module mcp_prom_model (
    // Clock
    input wire aclk,
    // Programming side
    input wire [12:0] prom_latch_addr,
    input wire [7:0] prom_latch_data,
    input wire prom_latched,
    input wire prom_high_voltage_enable
);
    logic [7:0] mem [0:8191];
    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = `MCP_PROM_ERASED;
    end
    // Programming only raises bits; a one never goes back to zero
    always @(posedge aclk) begin
        if (prom_high_voltage_enable && prom_latched) begin
            mem[prom_latch_addr] <= mem[prom_latch_addr] | prom_latch_data;
        end
    end
endmodule

//--- dv/mcp_memory_ctrl_tb.sv
/*
 Bench for the memory control block: AXI4-Lite access, decode scan, programming.
 Assumes the PROM model on the latch outputs and the checker bound below.
*/
`timescale 1ns/10ps
`include "mcp_consts.vh"
module mcp_memory_ctrl_tb;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic cpu_wr = 0, stack_push = 0, stack_pull = 0, lockout_cell_in = 0;
    logic [14:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, d;
    logic [12:0] cpu_addr = 0;
    logic [7:0] cpu_wdata = 0;
    logic [1:0] r;
    wire awready, wready, bvalid, arready, rvalid, bootloader_enable, irq_level_sense;
    wire page_zero_ram_select, page_one_ram_select, prom_latched, prom_high_voltage_enable;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [2:0] cpu_region;
    wire [7:0] stack_ptr, prom_latch_data;
    wire [12:0] prom_latch_addr;
    integer mismatches = 0, checks = 0, n, a, k, cnt;
    initial forever #50 aclk = ~aclk;
    mcp_memory_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .stack_push(stack_push),
        .stack_pull(stack_pull), .cpu_region(cpu_region), .stack_ptr(stack_ptr),
        .lockout_cell_in(lockout_cell_in), .bootloader_enable(bootloader_enable),
        .irq_level_sense(irq_level_sense), .page_zero_ram_select(page_zero_ram_select),
        .page_one_ram_select(page_one_ram_select), .prom_latch_addr(prom_latch_addr),
        .prom_latch_data(prom_latch_data), .prom_latched(prom_latched),
        .prom_high_voltage_enable(prom_high_voltage_enable));
    mcp_prom_model prom (.aclk(aclk), .prom_latch_addr(prom_latch_addr),
        .prom_latch_data(prom_latch_data), .prom_latched(prom_latched),
        .prom_high_voltage_enable(prom_high_voltage_enable));
    task report_and_stop;
        begin
            if (mismatches == 0 && checks > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    // Wide enough that a response code packed above a 32-bit word is still compared
    task chk(input [63:0] seen, input [63:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Write waits for the response, dropping each valid as its channel is taken
    task wr(input [14:0] ad, input [7:0] v);
        begin
            @(posedge aclk);
            awaddr <= ad;
            wdata <= {24'h0, v};
            awvalid <= 1;
            wvalid <= 1;
            bready <= 1;
            n = 0;
            do begin
                @(posedge aclk);
                if (awready === 1'b1) awvalid <= 0;
                if (wready === 1'b1) wvalid <= 0;
                n = n + 1;
            end while (bvalid !== 1'b1 && n < 50);
            r = bresp;
            bready <= 0;
            if (n >= 50) begin
                mismatches = mismatches + 1;
                report_and_stop;
            end
        end
    endtask
    task rd(input [14:0] ad);
        begin
            @(posedge aclk);
            araddr <= ad;
            arvalid <= 1;
            rready <= 1;
            n = 0;
            do begin
                @(posedge aclk);
                if (arready === 1'b1) arvalid <= 0;
                n = n + 1;
            end while (rvalid !== 1'b1 && n < 50);
            r = rresp;
            d = rdata;
            rready <= 0;
            if (n >= 50) begin
                mismatches = mismatches + 1;
                report_and_stop;
            end
        end
    endtask
    task cw(input [12:0] ad, input [7:0] v);
        begin
            @(posedge aclk);
            cpu_addr <= ad;
            cpu_wdata <= v;
            cpu_wr <= 1;
            @(posedge aclk);
            cpu_wr <= 0;
        end
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        #1;
        chk({stack_ptr, irq_level_sense}, {8'hFF, 1'b1});
        chk({page_zero_ram_select, page_one_ram_select}, 0);
        chk({prom_high_voltage_enable, prom_latched}, 0);
        repeat (8) @(posedge aclk);
        chk(bootloader_enable, 1);
        rd(`MCP_ADDR_PROM_PROGRAM_CONTROL);
        chk({r, d}, 0);
        rd(`MCP_ADDR_OPTION);
        chk(d & 32'hFB, 32'h02);
        rd(15'h0004);
        chk({r, d}, {`MCP_RESP_SLVERR, 32'h0});
        wr(15'h0004, 8'hFF);
        chk(r, `MCP_RESP_SLVERR);
        for (k = 0; k < 4; k++) begin
            wr(`MCP_ADDR_OPTION, {k[0], k[1], 6'h02});
            chk({page_zero_ram_select, page_one_ram_select}, {k[0], k[1]});
            rd(`MCP_ADDR_OPTION);
            chk(d & 32'hC0, {k[0], k[1], 6'h00});
            cnt = 0;
            // Region seen after each edge belongs to the address set one edge before
            for (a = 0; a <= 8192; a++) begin
                @(posedge aclk);
                cpu_addr <= a[12:0];
                #1;
                if (a > 0 && cpu_region === `MCP_RG_RAM) cnt = cnt + 1;
            end
            chk(cnt, 176 + 32 * k[0] + 96 * k[1]);
        end
        wr(`MCP_ADDR_OPTION, 8'h00);
        chk(irq_level_sense, 1);
        cw(13'h0123, 8'hA5);
        @(posedge aclk);
        #1;
        chk(prom_latched, 0);
        wr(`MCP_ADDR_PROM_PROGRAM_CONTROL, 8'h01);
        rd(`MCP_ADDR_PROM_PROGRAM_CONTROL);
        chk({prom_high_voltage_enable, d}, 0);
        wr(`MCP_ADDR_PROM_PROGRAM_CONTROL, 8'h04);
        rd(`MCP_ADDR_PROM_PROGRAM_CONTROL);
        chk(d, 32'h04);
        cw(13'h0123, 8'hA5);
        cw(13'h0456, 8'h5A);
        @(posedge aclk);
        #1;
        chk({prom_latched, prom_latch_addr, prom_latch_data}, {1'b1, 13'h0123, 8'hA5});
        wr(`MCP_ADDR_PROM_PROGRAM_CONTROL, 8'hFF);
        rd(`MCP_ADDR_PROM_PROGRAM_CONTROL);
        chk({prom_high_voltage_enable, d}, {1'b1, 32'h05});
        repeat (4) @(posedge aclk);
        chk({prom.mem[13'h0123], prom.mem[13'h0456]}, 16'hA500);
        wr(`MCP_ADDR_PROM_PROGRAM_CONTROL, 8'h00);
        chk({prom_high_voltage_enable, prom_latched}, 0);
        @(posedge aclk);
        stack_push <= 1;
        repeat (3) @(posedge aclk);
        stack_pull <= 1;
        @(posedge aclk);
        stack_push <= 0;
        @(posedge aclk);
        stack_pull <= 0;
        #1;
        chk(stack_ptr, 8'hFD);
        wr(`MCP_ADDR_OPTION, 8'hC0);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        #1;
        chk({page_zero_ram_select, page_one_ram_select, irq_level_sense}, 1);
        rd(`MCP_ADDR_OPTION);
        chk(d[3], 0);
        wr(`MCP_ADDR_OPTION, 8'h00);
        chk({r, irq_level_sense}, {`MCP_RESP_OKAY, 1'b0});
        report_and_stop;
    end
endmodule
bind mcp_memory_ctrl mcp_memory_ctrl_sva u_sva (.aclk(aclk), .aresetn(aresetn),
    .cpu_addr(cpu_addr), .stack_push(stack_push), .stack_pull(stack_pull),
    .cpu_region(cpu_region), .stack_ptr(stack_ptr), .irq_level_sense(irq_level_sense),
    .page_zero_ram_select(page_zero_ram_select), .page_one_ram_select(page_one_ram_select),
    .prom_latch_addr(prom_latch_addr), .prom_latched(prom_latched),
    .prom_high_voltage_enable(prom_high_voltage_enable));
